// >>> hdl/spwm_pkg.sv
package spwm_pkg;

    // ****************************************************************
    // Geometry and defaults
    // ****************************************************************
    localparam int SPWM_POS_W = 32;
    localparam int SPWM_NUM_CAM = 3;
    localparam int SPWM_NUM_LIM = 3;
    localparam int SPWM_NUM_SOUT = 8;
    localparam int SPWM_NUM_SIN = 8;
    localparam int SPWM_CLK_MHZ = 100;
    // Delay given in ms; cycles per ms derived from the clock rate
    localparam int SPWM_DELAY_MS_DEF = 0;
    localparam int SPWM_CYC_PER_MS = SPWM_CLK_MHZ * 1000;
    localparam int SPWM_DELAY_W = 16;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    // Activation source of one instance
    typedef enum logic [1:0] {
        SPWM_ACT_NEVER = 2'b00,
        SPWM_ACT_INPUT = 2'b01,
        SPWM_ACT_BUS = 2'b10
    } spwm_act_t;

    // Selected fault reaction
    typedef enum logic [1:0] {
        SPWM_FR_TORQUE_OFF = 2'b01,
        SPWM_FR_STOP_ONE = 2'b10,
        SPWM_FR_STOP_TWO = 2'b11
    } spwm_fr_t;

    // Internal state field of a limited-position instance
    typedef enum logic [1:0] {
        SPWM_ST_IDLE = 2'b00,
        SPWM_ST_ACTIVE = 2'b01,
        SPWM_ST_FAILED = 2'b10
    } spwm_state_t;

    // Status source index for output mapping: cams 0..2, limits 3..5
    localparam int SPWM_NUM_STAT = SPWM_NUM_CAM + SPWM_NUM_LIM;
    localparam int SPWM_SEL_W = 3;
    localparam logic [SPWM_SEL_W-1:0] SPWM_SEL_NONE = 3'h7;

endpackage

// >>> hdl/spwm_cfg_if.sv
`timescale 1ns/100ps
// Configuration and result of one limited-position instance
interface spwm_lim_if;
    import spwm_pkg::*;
    logic signed [SPWM_POS_W-1:0] upper;
    logic signed [SPWM_POS_W-1:0] lower;
    spwm_act_t act_sel;
    logic act_req;
    logic [SPWM_DELAY_W-1:0] delay_ms;
    logic active;
    logic fault;
    spwm_state_t state;
    modport top (output upper, output lower, output act_sel, output act_req, output delay_ms,
                 input active, input fault, input state);
    modport mon (input upper, input lower, input act_sel, input act_req, input delay_ms,
                 output active, output fault, output state);
endinterface

// >>> hdl/spwm_limit_mon.sv
`timescale 1ns/100ps
module spwm_limit_mon
    import spwm_pkg::*;
#(
    parameter int CYC_PER_MS = SPWM_CYC_PER_MS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic signed [SPWM_POS_W-1:0] pos_in,
    input wire logic pos_valid_in,
    spwm_lim_if.mon lim
);

    // ****************************************************************
    // Activation, start delay and fault latch
    // ****************************************************************
    localparam int MS_W = $clog2(CYC_PER_MS + 1);
    logic [MS_W-1:0] ms_cnt;
    logic [SPWM_DELAY_W-1:0] ms_left;
    logic enabled;
    logic armed;
    logic outside;
    spwm_state_t state;

    initial begin
        if (CYC_PER_MS < 1) begin
            $error("CYC_PER_MS must be at least one");
        end
    end

    // Never active keeps the instance idle whatever the request
    assign enabled = (lim.act_sel != SPWM_ACT_NEVER) && lim.act_req;
    // Inclusive window, taken on each new sample
    assign outside = (pos_in > lim.upper) || (pos_in < lim.lower);

    // Start delay counts whole ms after activation
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ms_cnt <= '0;
            ms_left <= '0;
            armed <= 1'b0;
        end else if (!enabled) begin
            ms_cnt <= '0;
            ms_left <= lim.delay_ms;
            armed <= 1'b0;
        end else if (ms_left == '0) begin
            armed <= 1'b1;
        end else if (ms_cnt == MS_W'(CYC_PER_MS - 1)) begin
            ms_cnt <= '0;
            ms_left <= ms_left - 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    // Failed state holds while active; only deactivation leaves it
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= SPWM_ST_IDLE;
        end else if (!enabled) begin
            state <= SPWM_ST_IDLE;
        end else if (state == SPWM_ST_FAILED) begin
            state <= SPWM_ST_FAILED;
        end else if (armed && pos_valid_in && outside) begin
            state <= SPWM_ST_FAILED;
        end else begin
            state <= SPWM_ST_ACTIVE;
        end
    end

    assign lim.state = state;
    assign lim.active = (state != SPWM_ST_IDLE);
    assign lim.fault = (state == SPWM_ST_FAILED);

endmodule

// >>> hdl/spwm_monitor.sv
`timescale 1ns/100ps
// Overview of operation
// - Limited-position fault selects reaction: torque off default, or stop one/two.
// - On fault the limited-position instance stays active, state becomes failed (2).
// - Status flags reach safe outputs only when mapped; outputs pair to dual channel.
// - Cam instances only monitor, never fault, always active once configured.
// - Cam flag high while position lies between lower and upper limit.
// - Three independent cam instances with own limits and flags.
// - Each limited-position instance picks input or fieldbus as activation source.
// - Reaction sources: safety functions, I/O failures, critical internal failures.
// - Torque off and stop one stay available; configuration cannot disable them.
// - Limited-position faults when position leaves window while active.
// - Monitoring start may be delayed by a configured time in ms.
module spwm_monitor
    import spwm_pkg::*;
#(
    parameter int CYC_PER_MS = SPWM_CYC_PER_MS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic signed [SPWM_POS_W-1:0] pos_in,
    input wire logic pos_valid_in,
    input wire logic [SPWM_NUM_SIN-1:0] safe_in,
    input wire logic [SPWM_NUM_LIM-1:0] bus_act_in,
    input wire logic io_fail_in,
    input wire logic internal_fail_in,
    input wire logic [SPWM_NUM_CAM-1:0] cam_cfg_in,
    input wire logic [SPWM_NUM_CAM*SPWM_POS_W-1:0] cam_upper_limit_in,
    input wire logic [SPWM_NUM_CAM*SPWM_POS_W-1:0] cam_lower_limit_in,
    input wire logic [SPWM_NUM_LIM*SPWM_POS_W-1:0] position_upper_limit_in,
    input wire logic [SPWM_NUM_LIM*SPWM_POS_W-1:0] position_lower_limit_in,
    input wire logic [SPWM_NUM_LIM*2-1:0] lim_act_sel_in,
    input wire logic [SPWM_NUM_LIM*3-1:0] lim_input_idx_in,
    input wire logic [SPWM_NUM_LIM*SPWM_DELAY_W-1:0] monitor_start_delay_in,
    input wire logic [SPWM_NUM_LIM*2-1:0] lim_reaction_in,
    input wire logic [SPWM_NUM_SOUT*SPWM_SEL_W-1:0] sout_map_in,
    input wire logic [SPWM_NUM_SOUT/2-1:0] sout_dual_in,
    input wire logic [31:0] irq_clear_in,
    input wire logic irq_clear_wr_in,
    input wire logic [31:0] irq_enable_in,
    input wire logic irq_enable_wr_in,
    output logic [SPWM_NUM_CAM-1:0] window_hit_flag_out,
    output logic [SPWM_NUM_LIM-1:0] lim_active_out,
    output logic [SPWM_NUM_LIM*2-1:0] function_state_field_out,
    output logic safe_torque_off_out,
    output logic controlled_stop_one_out,
    output logic controlled_stop_two_out,
    output logic [SPWM_NUM_SOUT-1:0] safe_out,
    output logic [31:0] irq_status_out,
    output logic irq_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    initial begin
        if (SPWM_NUM_SIN > 8 || (SPWM_NUM_SOUT % 2) != 0) begin
            $error("input index is 3 bits and outputs must pair");
        end
    end

    // Map a raw 2-bit code to a reaction; illegal codes fall back to torque off
    function automatic spwm_fr_t spwm_fr_decode(input logic [1:0] code);
        spwm_fr_t r;
        r = SPWM_FR_TORQUE_OFF;
        unique case (code)
            2'b10: r = SPWM_FR_STOP_ONE;
            2'b11: r = SPWM_FR_STOP_TWO;
            default: r = SPWM_FR_TORQUE_OFF;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Cam instances
    // ****************************************************************
    logic [SPWM_NUM_CAM-1:0] cam_hit;

    // Cams run whenever configured; no fault path exists at all
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cam_hit <= '0;
        end else begin
            for (int i = 0; i < SPWM_NUM_CAM; i++) begin
                if (!cam_cfg_in[i]) begin
                    cam_hit[i] <= 1'b0;
                end else if (pos_valid_in) begin
                    // Inclusive bounds, new sample only
                    cam_hit[i] <= (pos_in <= $signed(cam_upper_limit_in[i*SPWM_POS_W +: SPWM_POS_W])) &&
                        (pos_in >= $signed(cam_lower_limit_in[i*SPWM_POS_W +: SPWM_POS_W]));
                end
            end
        end
    end
    assign window_hit_flag_out = cam_hit;

    // ****************************************************************
    // Limited-position instances
    // ****************************************************************
    logic [SPWM_NUM_LIM-1:0] lim_fault;
    logic [SPWM_NUM_LIM-1:0] lim_active;
    logic [SPWM_NUM_LIM*2-1:0] lim_state;

    genvar g;
    generate
        for (g = 0; g < SPWM_NUM_LIM; g++) begin : gen_lim
            spwm_lim_if lif ();
            logic [2:0] in_idx;
            assign in_idx = lim_input_idx_in[g*3 +: 3];
            assign lif.upper = $signed(position_upper_limit_in[g*SPWM_POS_W +: SPWM_POS_W]);
            assign lif.lower = $signed(position_lower_limit_in[g*SPWM_POS_W +: SPWM_POS_W]);
            assign lif.act_sel = spwm_act_t'(lim_act_sel_in[g*2 +: 2]);
            assign lif.delay_ms = monitor_start_delay_in[g*SPWM_DELAY_W +: SPWM_DELAY_W];
            // Source chosen per instance
            assign lif.act_req = (lif.act_sel == SPWM_ACT_INPUT) ? safe_in[in_idx] :
                                 (lif.act_sel == SPWM_ACT_BUS) ? bus_act_in[g] : 1'b0;
            spwm_limit_mon #(
                .CYC_PER_MS(CYC_PER_MS)
            ) u_mon (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .pos_in(pos_in),
                .pos_valid_in(pos_valid_in),
                .lim(lif)
            );
            assign lim_fault[g] = lif.fault;
            assign lim_active[g] = lif.active;
            assign lim_state[g*2 +: 2] = lif.state;
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lim_active_out <= '0;
            function_state_field_out <= '0;
        end else begin
            lim_active_out <= lim_active;
            function_state_field_out <= lim_state;
        end
    end

    // ****************************************************************
    // Fault reaction collection
    // ****************************************************************
    logic next_sto;
    logic next_ss1;
    logic next_ss2;

    // Per-instance reaction choice; failures always go to torque off
    always_comb begin
        next_sto = io_fail_in || internal_fail_in;
        next_ss1 = 1'b0;
        next_ss2 = 1'b0;
        for (int i = 0; i < SPWM_NUM_LIM; i++) begin
            if (lim_fault[i]) begin
                unique case (spwm_fr_decode(lim_reaction_in[i*2 +: 2]))
                    SPWM_FR_STOP_ONE: next_ss1 = 1'b1;
                    SPWM_FR_STOP_TWO: next_ss2 = 1'b1;
                    SPWM_FR_TORQUE_OFF: next_sto = 1'b1;
                endcase
            end
        end
    end

    // Torque off and stop one have no disable gate by design
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            safe_torque_off_out <= 1'b0;
            controlled_stop_one_out <= 1'b0;
            controlled_stop_two_out <= 1'b0;
        end else begin
            safe_torque_off_out <= next_sto;
            controlled_stop_one_out <= next_ss1;
            controlled_stop_two_out <= next_ss2;
        end
    end

    // ****************************************************************
    // Safe output mapping
    // ****************************************************************
    logic [SPWM_NUM_STAT-1:0] stat_vec;
    logic [SPWM_NUM_SOUT-1:0] next_sout;
    assign stat_vec = {lim_active, cam_hit};

    // Unmapped outputs stay low; a dual pair follows its first channel
    always_comb begin
        next_sout = '0;
        for (int o = 0; o < SPWM_NUM_SOUT; o++) begin
            logic [SPWM_SEL_W-1:0] sel;
            sel = sout_map_in[o*SPWM_SEL_W +: SPWM_SEL_W];
            if (sout_dual_in[o/2] && (o % 2) == 1) begin
                next_sout[o] = next_sout[o-1];
            end else if (sel != SPWM_SEL_NONE && int'(sel) < SPWM_NUM_STAT) begin
                next_sout[o] = stat_vec[sel];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            safe_out <= '0;
        end else begin
            safe_out <= next_sout;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // Events: bit0..2 limit faults rising, bit3..5 cam changes, bit6 io, bit7 internal
    logic [7:0] evt;
    logic [SPWM_NUM_LIM-1:0] fault_d;
    logic [SPWM_NUM_CAM-1:0] cam_d;
    logic [7:0] irq_en;
    logic [7:0] irq_sts;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fault_d <= '0;
            cam_d <= '0;
        end else begin
            fault_d <= lim_fault;
            cam_d <= cam_hit;
        end
    end
    assign evt = {internal_fail_in, io_fail_in, cam_hit ^ cam_d, lim_fault & ~fault_d};

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_sts <= '0;
        end else if (irq_clear_wr_in) begin
            irq_sts <= (irq_sts & ~irq_clear_in[7:0]) | evt;
        end else begin
            irq_sts <= irq_sts | evt;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_en <= '0;
        end else if (irq_enable_wr_in) begin
            irq_en <= irq_enable_in[7:0];
        end
    end

    assign irq_status_out = {24'h00_0000, irq_sts};
    assign irq_out = |(irq_sts & irq_en);

endmodule

// >>> verification/spwm_monitor_chk.sv
`timescale 1ns/100ps
// Ties each monitor flag to its cause at the pins
module spwm_monitor_chk
    import spwm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic signed [SPWM_POS_W-1:0] pos_in,
    input wire logic pos_valid_in,
    input wire logic [SPWM_NUM_LIM-1:0] bus_act_in,
    input wire logic io_fail_in,
    input wire logic [SPWM_NUM_CAM-1:0] cam_cfg_in,
    input wire logic [SPWM_NUM_CAM*SPWM_POS_W-1:0] cam_upper_limit_in,
    input wire logic [SPWM_NUM_CAM*SPWM_POS_W-1:0] cam_lower_limit_in,
    input wire logic [SPWM_NUM_LIM*2-1:0] lim_act_sel_in,
    input wire logic [SPWM_NUM_LIM*2-1:0] lim_reaction_in,
    input wire logic [SPWM_NUM_SOUT*SPWM_SEL_W-1:0] sout_map_in,
    input wire logic [SPWM_NUM_SOUT/2-1:0] sout_dual_in,
    input wire logic [SPWM_NUM_CAM-1:0] window_hit_flag_out,
    input wire logic [SPWM_NUM_LIM-1:0] lim_active_out,
    input wire logic [SPWM_NUM_LIM*2-1:0] function_state_field_out,
    input wire logic safe_torque_off_out,
    input wire logic controlled_stop_one_out,
    input wire logic [SPWM_NUM_SOUT-1:0] safe_out,
    input wire logic [31:0] irq_status_out
);
    // ***
    // Helpers
    // ***
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Cam 0 window, both ends inclusive, compared signed
    logic in_win;
    assign in_win = pos_in >= $signed(cam_lower_limit_in[31:0]) && pos_in <= $signed(cam_upper_limit_in[31:0]);
    // ***
    // Properties
    // ***
    cam_flag_a:
        assert property (pos_valid_in && cam_cfg_in[0] ##1 cam_cfg_in[0] |-> window_hit_flag_out[0] == $past(in_win))
        else $error("cam flag off");
    cam_unused_a:
        assert property (!cam_cfg_in[2] [*2] |-> !window_hit_flag_out[2]) else $error("unconfigured cam flag");
    never_on_a:
        assert property (lim_act_sel_in[3:2] == 2'b00 [*3] |-> !lim_active_out[1] && function_state_field_out[3:2] == 2'b00)
        else $error("never-active instance moved");
    fail_sticky_a:
        assert property ((lim_act_sel_in[1:0] == 2'b10 && bus_act_in[0]) [*3] ##0 function_state_field_out[1:0] == 2'b10
            |=> function_state_field_out[1:0] == 2'b10 && lim_active_out[0]) else $error("failed state lost");
    stop_pick_a:
        assert property ($rose(function_state_field_out[3]) && lim_reaction_in[3:2] == 2'b10 |-> controlled_stop_one_out)
        else $error("stop one not raised");
    io_stop_a:
        assert property (io_fail_in [*3] |-> safe_torque_off_out) else $error("io failure without torque off");
    io_flag_a:
        assert property (io_fail_in [*2] |-> irq_status_out[6]) else $error("io failure not flagged");
    sout_cam_a:
        assert property (sout_map_in[2:0] == 3'h0 [*2] |-> safe_out[0] == $past(window_hit_flag_out[0]))
        else $error("mapped output off");
    sout_none_a:
        assert property (sout_map_in[2:0] == 3'h7 [*2] |-> !safe_out[0]) else $error("unmapped output set");
    sout_pair_a:
        assert property (sout_dual_in[0] [*2] |-> safe_out[1] == safe_out[0]) else $error("pair differs");
endmodule
bind spwm_monitor spwm_monitor_chk i_spwm_monitor_chk (.*);

// >>> verification/spwm_feedback_model.sv
`timescale 1ns/100ps
// Safe feedback source: one sample per call
module spwm_feedback_model
    import spwm_pkg::*;
(
    input wire logic clk_in,
    output logic signed [SPWM_POS_W-1:0] pos_out,
    output logic pos_valid_out
);
    // ***
    // Sample delivery
    // ***
    initial begin
        pos_out = '0;
        pos_valid_out = 1'b0;
    end
    // Stale value inverted so nothing can lean on it after the strobe
    task automatic send(input int p);
        @(posedge clk_in);
        pos_out <= SPWM_POS_W'(p);
        pos_valid_out <= 1'b1;
        @(posedge clk_in);
        pos_out <= ~SPWM_POS_W'(p);
        pos_valid_out <= 1'b0;
    endtask
endmodule

// >>> verification/spwm_monitor_test.sv
`timescale 1ns/100ps
// Self-checking bench for the window monitor
module spwm_monitor_test;
    import spwm_pkg::*;
    // ***
    // Stimulus state
    // ***
    int clo[3] = '{-10, 100, 0};
    int chi[3] = '{10, 200, 0};
    int llo[3] = '{-50, -5, 0};
    int lhi[3] = '{50, 5, 10};
    int pt[8] = '{-11, -10, 10, 11, 100, 200, 201, 0};
    int n_fail = 0;
    int compares = 0;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic signed [SPWM_POS_W-1:0] pos;
    logic pos_valid;
    logic [SPWM_NUM_SIN-1:0] safe_in = '0;
    logic [SPWM_NUM_LIM-1:0] bus_act = '0;
    logic io_fail = 1'b0;
    logic int_fail = 1'b0;
    logic [SPWM_NUM_CAM-1:0] cam_cfg = 3'h3;
    logic [5:0] act_sel = 6'h26; // Bus, safe input 3, bus
    logic [5:0] react = 6'h15;
    logic [23:0] smap = 24'hFF_FFFF;
    logic [3:0] dual = '0;
    logic [8:0] in_idx = 9'h018; // Inst1 starts on safe input 3
    logic [47:0] dly = '0; // Start delays, loaded while an instance is idle
    logic [31:0] irq_val = '0;
    logic clr_wr = 1'b0;
    logic en_wr = 1'b0;
    logic [2:0] hit;
    logic [2:0] act;
    logic [5:0] st;
    logic safe_torque_off;
    logic ss1;
    logic ss2;
    logic [7:0] sout;
    logic [31:0] irq_st;
    logic irq;
    // Clock
    always #5 clk_in = ~clk_in;
    spwm_feedback_model i_spwm_feedback_model (.clk_in(clk_in), .pos_out(pos), .pos_valid_out(pos_valid));
    // Short ms so the start delay stays a few cycles
    spwm_monitor #(.CYC_PER_MS(10)) i_spwm_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in), .pos_in(pos),
        .pos_valid_in(pos_valid), .safe_in(safe_in), .bus_act_in(bus_act), .io_fail_in(io_fail),
        .internal_fail_in(int_fail), .cam_cfg_in(cam_cfg),
        .cam_upper_limit_in({32'(chi[2]), 32'(chi[1]), 32'(chi[0])}),
        .cam_lower_limit_in({32'(clo[2]), 32'(clo[1]), 32'(clo[0])}),
        .position_upper_limit_in({32'(lhi[2]), 32'(lhi[1]), 32'(lhi[0])}),
        .position_lower_limit_in({32'(llo[2]), 32'(llo[1]), 32'(llo[0])}),
        .lim_act_sel_in(act_sel), .lim_input_idx_in(in_idx), .monitor_start_delay_in(dly),
        .lim_reaction_in(react), .sout_map_in(smap), .sout_dual_in(dual), .irq_clear_in(irq_val),
        .irq_clear_wr_in(clr_wr), .irq_enable_in(irq_val), .irq_enable_wr_in(en_wr), .window_hit_flag_out(hit),
        .lim_active_out(act), .function_state_field_out(st), .safe_torque_off_out(safe_torque_off),
        .controlled_stop_one_out(ss1), .controlled_stop_two_out(ss2), .safe_out(sout), .irq_status_out(irq_st),
        .irq_out(irq));
    // ***
    // Tasks
    // ***
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Let the edges land before looking
    task automatic ed(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic irq_w(input logic [31:0] v, input logic en);
        @(posedge clk_in);
        irq_val <= v;
        en_wr <= en;
        clr_wr <= ~en;
        @(posedge clk_in);
        en_wr <= 1'b0;
        clr_wr <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        print_verdict();
    end
    // ***
    // Scenarios
    // ***
    initial begin
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            i_spwm_feedback_model.send(pt[i]);
            ed(1);
            for (int c = 0; c < 3; c++)
                chk("cam flag", 32'(c < 2 && pt[i] >= clo[c] && pt[i] <= chi[c]), 32'(hit[c]));
            chk("cam reaction", 0, {safe_torque_off, ss1, ss2});
        end
        @(posedge clk_in);
        cam_cfg <= 3'h7;
        clo[2] <= 6;
        chi[2] <= 6;
        // Single-point window: only an inclusive compare can hit it
        i_spwm_feedback_model.send(6);
        ed(1);
        chk("cam2 flag", 1, hit[2]);
        i_spwm_feedback_model.send(7);
        ed(1);
        chk("cam2 flag", 0, hit[2]);
        $display("test cams done");
        @(posedge clk_in);
        bus_act <= 3'h1;
        ed(3);
        i_spwm_feedback_model.send(50);
        ed(2);
        chk("edge inside", 1, st[1:0]);
        i_spwm_feedback_model.send(51);
        ed(2);
        chk("lim fail", 6'h2C, {st[1:0], act[0], safe_torque_off, ss1, ss2});
        ed(4);
        chk("lim held", 4'hB, {st[1:0], act[0], irq_st[0]});
        @(posedge clk_in);
        bus_act <= 3'h0;
        ed(4);
        chk("lim idle", 0, {st[1:0], act[0], safe_torque_off});
        for (int k = 1; k < 4; k++) begin
            @(posedge clk_in);
            react[3:2] <= 2'(k);
            in_idx[5:3] <= 3'(k + 3);
            safe_in[k + 3] <= 1'b1;
            ed(3);
            i_spwm_feedback_model.send(-6);
            ed(2);
            chk("reaction", 32'(3'h4 >> (k - 1)), {safe_torque_off, ss1, ss2});
            @(posedge clk_in);
            safe_in[k + 3] <= 1'b0;
            ed(4);
            chk("reaction off", 0, {st[3:2], safe_torque_off, ss1, ss2});
        end
        @(posedge clk_in);
        act_sel[3:2] <= 2'b00;
        safe_in[6] <= 1'b1;
        dly[47:32] <= 16'h0001; // Set early so the idle instance latches it
        ed(3);
        i_spwm_feedback_model.send(-100);
        ed(3);
        chk("never active", 0, {act[1], st[3:2], safe_torque_off, ss1, ss2});
        $display("test limits done");
        @(posedge clk_in);
        safe_in[6] <= 1'b0;
        bus_act <= 3'h4;
        llo[2] <= -20;
        lhi[2] <= 20;
        ed(2);
        i_spwm_feedback_model.send(50);
        ed(2);
        chk("delay early", 0, {st[5], safe_torque_off});
        ed(12);
        i_spwm_feedback_model.send(50);
        ed(2);
        chk("delay armed", 3'h5, {st[5:4], safe_torque_off});
        @(posedge clk_in);
        bus_act <= 3'h0;
        ed(4);
        $display("test delay done");
        irq_w(32'hFFFF_FFFF, 1'b0);
        irq_w(32'h0000_0040, 1'b1);
        ed(1);
        chk("irq idle", 0, irq);
        @(posedge clk_in);
        io_fail <= 1'b1;
        ed(3);
        chk("io fail", 3'h7, {safe_torque_off, irq_st[6], irq});
        @(posedge clk_in);
        io_fail <= 1'b0;
        int_fail <= 1'b1;
        ed(3);
        irq_w(32'h0000_0040, 1'b0);
        ed(1);
        chk("internal fail", 3'h6, {safe_torque_off, irq_st[7], irq});
        @(posedge clk_in);
        int_fail <= 1'b0;
        ed(3);
        chk("fail released", 0, {safe_torque_off, irq});
        $display("test faults done");
        chk("unmapped", 0, sout);
        @(posedge clk_in);
        smap <= 24'hFF_FEF8; // Out0 cam 0, out2 limit 0
        i_spwm_feedback_model.send(0);
        ed(3);
        chk("mapped", 3'h1, sout[2:0]);
        @(posedge clk_in);
        dual <= 4'h1;
        bus_act <= 3'h1;
        ed(4);
        chk("pair", 3'h7, sout[2:0]);
        i_spwm_feedback_model.send(50);
        ed(4);
        chk("cam left", 3'h4, sout[2:0]);
        $display("test outputs done");
        print_verdict();
    end
endmodule
